// file: src/hisc_pkg.sv
// Purpose: Shared constants and types for the host interface strap configuration block
// Assumes: Straps are static after reset release
// Notes:   Select codes and link, command and bus width encodings
package hisc_pkg;

    // Interface select codes
    localparam logic [3:0] SEL_PAR8      = 4'h0;
    localparam logic [3:0] SEL_PAR16     = 4'h1;
    localparam logic [3:0] SEL_PAR24     = 4'h2;
    localparam logic [3:0] SEL_RGB_SPIR  = 4'h3;
    localparam logic [3:0] SEL_RGB_SPIF  = 4'hB;
    localparam logic [3:0] SEL_RGB_I2C   = 4'h4;
    localparam logic [3:0] SEL_DSI       = 4'h5;
    localparam logic [3:0] SEL_MDDI_SPIR = 4'h6;
    localparam logic [3:0] SEL_MDDI_SPIF = 4'hE;
    localparam logic [3:0] SEL_MDDI_I2C  = 4'h7;

    // I2C slave address, upper six bits and low bit choice
    localparam logic [5:0] I2C_ADDR_HI  = 6'h26;

    // Cycles after reset release before straps are captured
    localparam int unsigned STRAP_SETTLE_CYC = 2;

    // PWM period in clock cycles (256 duty steps)
    localparam int unsigned PWM_STEPS = 256;

    // Data path width choice of the parallel port
    typedef enum logic [1:0] {
        HISC_BUS_NONE,
        HISC_BUS_8,
        HISC_BUS_16,
        HISC_BUS_24
    } hisc_bus_e;

    // Host link kind
    typedef enum logic [2:0] {
        HISC_LINK_INVALID,
        HISC_LINK_PARALLEL,
        HISC_LINK_RGB,
        HISC_LINK_DSI,
        HISC_LINK_MDDI
    } hisc_link_e;

    // Command channel kind
    typedef enum logic [2:0] {
        HISC_CMD_NONE,
        HISC_CMD_PARALLEL,
        HISC_CMD_SPI_RISE,
        HISC_CMD_SPI_FALL,
        HISC_CMD_I2C,
        HISC_CMD_DSI
    } hisc_cmd_e;

endpackage

// file: src/hisc_pwm.sv
// Purpose: Backlight PWM generator with 256 duty levels
// Assumes: Duty 0 is constant low, full flag is constant high at any duty
// Notes:   Output registered; duty takes effect at period start
`timescale 1ns/1ps
`default_nettype none
module hisc_pwm
    import hisc_pkg::*;
#(
    parameter int unsigned W = 8
) (
    // Clock and reset
    input  wire logic         i_mclk,
    input  wire logic         i_reset_n,
    // Control
    input  wire logic         i_enable,
    input  wire logic [W-1:0] i_duty,
    input  wire logic         i_full,
    // Output
    output logic              o_pwm
);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic [W-1:0] duty_q;
    logic [W-1:0] duty_d;
    logic         full_q;
    logic         full_d;
    logic         pwm_q;
    logic         pwm_d;

    // Next state: counter wraps, duty sampled at wrap
    always_comb begin
        cnt_d  = cnt_q + W'(1);
        duty_d = duty_q;
        full_d = full_q;
        if (cnt_q == '1) begin
            duty_d = i_duty;
            full_d = i_full;
        end
        pwm_d = i_enable && (full_q || (cnt_q < duty_q)); // R14
    end

    // Registers
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt_q  <= '0;
            duty_q <= '0;
            full_q <= 1'b0;
            pwm_q  <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            duty_q <= duty_d;
            full_q <= full_d;
            pwm_q  <= pwm_d;
        end
    end

    assign o_pwm = pwm_q;

    // Zero duty keeps output low over a whole period
    property p_pwm_zero;
        @(posedge i_mclk) disable iff (!i_reset_n)
        (duty_q == '0 && !full_q) |=> !pwm_q;
    endproperty
    a_pwm_zero: assert property (p_pwm_zero) else $error("pwm high at zero duty"); // R14

    // Full flag keeps output high when enabled
    property p_pwm_full;
        @(posedge i_mclk) disable iff (!i_reset_n)
        (full_q && i_enable) |=> pwm_q;
    endproperty
    a_pwm_full: assert property (p_pwm_full) else $error("pwm low at full duty"); // R14

endmodule
`default_nettype wire

// file: src/hisc_top.sv
// Purpose: Strap capture and host interface configuration for a display driver
// Assumes: Straps constant from before reset release; inputs synchronous to i_mclk
// Notes:   All outputs registered; straps captured once after reset release
// Notes on behaviour
// R1: Codes 0000/0001/0010 pick parallel port of 8/16/24 bits.
// R2: RGB with SPI rise/fall or I2C, DSI, MDDI variants; others invalid.
// R3: Lane-count strap low gives one lane, high gives two lanes.
// R4: DSI honours both swaps; MDDI honours polarity swap only.
// R5: Lane-order swap exchanges lane 0 and lane 1; clock stays middle.
// R6: Polarity swap inverts every pair including clock, combined with order swap.
// R7: Error output low unless enabled; high on CRC or ECC error when enabled.
// R8: Tearing output low until enabled by command; then frame sync.
// R9: Second tearing output equals the primary one.
// R10: RGB bypass strap routes pixels to frame memory or line buffer.
// R11: I2C address is 1001100 or 1001101 from address strap.
// R12: Dual-IO regulator and voltage select only with dual-IO enable high.
// R13: Backlight on/off output drives external LED driver.
// R14: PWM brightness with 256 levels from constant low to constant high.
// R15: Four probe outputs driven, four inputs sensed for attach detection.
// R16: Board keeps straps constant; captured once after reset.
`timescale 1ns/1ps
`default_nettype none
module hisc_top
    import hisc_pkg::*;
#(
    parameter int unsigned PWM_W   = 8,
    parameter int unsigned PROBE_N = 4
) (
    // Clock and reset
    input  wire logic               i_mclk,
    input  wire logic               i_reset_n,
    // Straps
    input  wire logic [3:0]         i_interface_select_strap,
    input  wire logic               i_lane_count_strap,
    input  wire logic               i_lane_order_swap,
    input  wire logic               i_pair_polarity_swap,
    input  wire logic               i_rgb_bypass_strap,
    input  wire logic               i_slave_addr_lsb_strap,
    input  wire logic               i_io_voltage_select,
    input  wire logic               i_dual_io_enable_strap,
    // Runtime control from command decoder
    input  wire logic               i_err_enable,
    input  wire logic               i_crc_ecc_error,
    input  wire logic               i_tear_enable,
    input  wire logic               i_frame_sync,
    input  wire logic               i_backlight_on,
    input  wire logic [PWM_W-1:0]   i_pwm_duty,
    input  wire logic               i_pwm_full,
    input  wire logic [PROBE_N-1:0] i_attach_probe_in,
    // Decoded configuration
    output logic                    o_cfg_valid,
    output hisc_link_e              o_link_kind,
    output hisc_cmd_e               o_cmd_kind,
    output hisc_bus_e               o_bus_width,
    output logic                    o_two_lanes,
    output logic [1:0]              o_lane_map,
    output logic                    o_lane_pol,
    output logic                    o_rgb_to_line_buffer,
    output logic [6:0]              o_i2c_slave_addr,
    output logic                    o_dual_io_regulator,
    output logic                    o_io_level_1v8,
    // Pins
    output logic                    o_link_error,
    output logic                    o_tearing_sync_out_left,
    output logic                    o_tearing_sync_out_right,
    output logic                    o_backlight_on_out,
    output logic                    o_backlight_pwm_out,
    output logic [PROBE_N-1:0]      o_attach_probe_out,
    output logic                    o_attach_ok
);

    // Strap capture state
    logic [1:0] settle_q;
    logic [1:0] settle_d;
    logic       cap_q;
    logic       cap_d;
    hisc_link_e link_q, link_d;
    hisc_cmd_e  cmd_q, cmd_d;
    hisc_bus_e  bus_q, bus_d;
    logic       two_q, two_d;
    logic [1:0] map_q, map_d;
    logic       pol_q, pol_d;
    logic       byp_q, byp_d;
    logic [6:0] addr_q, addr_d;
    logic       dio_q, dio_d;
    logic       v18_q, v18_d;

    // Runtime pin state
    logic               err_q, err_d;
    logic               tear_q, tear_d;
    logic               tear_r_q, tear_r_d;
    logic               bl_q, bl_d;
    logic [PROBE_N-1:0] probe_q, probe_d;
    logic               ok_q, ok_d;

    // Strap decode: next values of the configuration, latched once
    always_comb begin
        settle_d = settle_q;
        cap_d    = cap_q;
        link_d   = link_q;
        cmd_d    = cmd_q;
        bus_d    = bus_q;
        two_d    = two_q;
        map_d    = map_q;
        pol_d    = pol_q;
        byp_d    = byp_q;
        addr_d   = addr_q;
        dio_d    = dio_q;
        v18_d    = v18_q;
        if (!cap_q) begin
            if (settle_q != 2'(STRAP_SETTLE_CYC)) begin
                settle_d = settle_q + 2'h1;
            end else begin
                cap_d  = 1'b1;                                // R16
                link_d = HISC_LINK_INVALID;
                cmd_d  = HISC_CMD_NONE;
                bus_d  = HISC_BUS_NONE;
                case (i_interface_select_strap)
                    SEL_PAR8: begin
                        link_d = HISC_LINK_PARALLEL;          // R1
                        cmd_d  = HISC_CMD_PARALLEL;
                        bus_d  = HISC_BUS_8;
                    end
                    SEL_PAR16: begin
                        link_d = HISC_LINK_PARALLEL;          // R1
                        cmd_d  = HISC_CMD_PARALLEL;
                        bus_d  = HISC_BUS_16;
                    end
                    SEL_PAR24: begin
                        link_d = HISC_LINK_PARALLEL;          // R1
                        cmd_d  = HISC_CMD_PARALLEL;
                        bus_d  = HISC_BUS_24;
                    end
                    SEL_RGB_SPIR: begin
                        link_d = HISC_LINK_RGB;               // R2
                        cmd_d  = HISC_CMD_SPI_RISE;
                    end
                    SEL_RGB_SPIF: begin
                        link_d = HISC_LINK_RGB;               // R2
                        cmd_d  = HISC_CMD_SPI_FALL;
                    end
                    SEL_RGB_I2C: begin
                        link_d = HISC_LINK_RGB;               // R2
                        cmd_d  = HISC_CMD_I2C;
                    end
                    SEL_DSI: begin
                        link_d = HISC_LINK_DSI;               // R2
                        cmd_d  = HISC_CMD_DSI;
                    end
                    SEL_MDDI_SPIR: begin
                        link_d = HISC_LINK_MDDI;              // R2
                        cmd_d  = HISC_CMD_SPI_RISE;
                    end
                    SEL_MDDI_SPIF: begin
                        link_d = HISC_LINK_MDDI;              // R2
                        cmd_d  = HISC_CMD_SPI_FALL;
                    end
                    SEL_MDDI_I2C: begin
                        link_d = HISC_LINK_MDDI;              // R2
                        cmd_d  = HISC_CMD_I2C;
                    end
                    default: begin
                        link_d = HISC_LINK_INVALID;           // R2
                    end
                endcase
                two_d  = i_lane_count_strap;                  // R3
                // Order swap only in DSI; polarity taken in every mode
                map_d  = (i_interface_select_strap == SEL_DSI && i_lane_order_swap)
                         ? 2'h1 : 2'h0;                       // R4 R5
                pol_d  = i_pair_polarity_swap;                // R4 R6
                byp_d  = i_rgb_bypass_strap;                  // R10
                addr_d = {I2C_ADDR_HI, i_slave_addr_lsb_strap}; // R11
                dio_d  = i_dual_io_enable_strap;              // R12
                v18_d  = i_dual_io_enable_strap && i_io_voltage_select; // R12
            end
        end
    end

    // Strap registers
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            settle_q <= 2'h0;
            cap_q    <= 1'b0;
            link_q   <= HISC_LINK_INVALID;
            cmd_q    <= HISC_CMD_NONE;
            bus_q    <= HISC_BUS_NONE;
            two_q    <= 1'b0;
            map_q    <= 2'h0;
            pol_q    <= 1'b0;
            byp_q    <= 1'b0;
            addr_q   <= 7'h00;
            dio_q    <= 1'b0;
            v18_q    <= 1'b0;
        end else begin
            settle_q <= settle_d;
            cap_q    <= cap_d;
            link_q   <= link_d;
            cmd_q    <= cmd_d;
            bus_q    <= bus_d;
            two_q    <= two_d;
            map_q    <= map_d;
            pol_q    <= pol_d;
            byp_q    <= byp_d;
            addr_q   <= addr_d;
            dio_q    <= dio_d;
            v18_q    <= v18_d;
        end
    end

    // Runtime pins: error, tearing, backlight, attach probes
    always_comb begin
        err_d    = i_err_enable && i_crc_ecc_error;           // R7
        tear_d   = i_tear_enable && i_frame_sync;             // R8
        tear_r_d = tear_d;                                    // R9
        bl_d     = i_backlight_on;                            // R13
        probe_d  = ~probe_q;                                  // R15
        ok_d     = (i_attach_probe_in == probe_q);            // R15
    end

    // Runtime registers
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            err_q    <= 1'b0;
            tear_q   <= 1'b0;
            tear_r_q <= 1'b0;
            bl_q     <= 1'b0;
            probe_q  <= '0;
            ok_q     <= 1'b0;
        end else begin
            err_q    <= err_d;
            tear_q   <= tear_d;
            tear_r_q <= tear_r_d;
            bl_q     <= bl_d;
            probe_q  <= probe_d;
            ok_q     <= ok_d;
        end
    end

    // Backlight PWM generator
    hisc_pwm #(
        .W        (PWM_W)
    ) u_pwm (
        .i_mclk   (i_mclk),
        .i_reset_n(i_reset_n),
        .i_enable (1'b1),
        .i_duty   (i_pwm_duty),
        .i_full   (i_pwm_full),
        .o_pwm    (o_backlight_pwm_out)                       // R14
    );

    // Output assignments
    assign o_cfg_valid              = cap_q;
    assign o_link_kind              = link_q;
    assign o_cmd_kind               = cmd_q;
    assign o_bus_width              = bus_q;
    assign o_two_lanes              = two_q;
    assign o_lane_map               = map_q;
    assign o_lane_pol               = pol_q;
    assign o_rgb_to_line_buffer     = byp_q;
    assign o_i2c_slave_addr         = addr_q;
    assign o_dual_io_regulator      = dio_q;
    assign o_io_level_1v8           = v18_q;
    assign o_link_error             = err_q;
    assign o_tearing_sync_out_left  = tear_q;
    assign o_tearing_sync_out_right = tear_r_q;
    assign o_backlight_on_out       = bl_q;
    assign o_attach_probe_out       = probe_q;
    assign o_attach_ok              = ok_q;

    // Assertions
    property p_err_off;
        @(posedge i_mclk) disable iff (!i_reset_n)
        !i_err_enable |=> !o_link_error;
    endproperty
    a_err_off: assert property (p_err_off) else $error("error out high while off"); // R7

    property p_err_on;
        @(posedge i_mclk) disable iff (!i_reset_n)
        (i_err_enable && i_crc_ecc_error) |=> o_link_error;
    endproperty
    a_err_on: assert property (p_err_on) else $error("error not flagged"); // R7

    property p_tear_off;
        @(posedge i_mclk) disable iff (!i_reset_n)
        !i_tear_enable |=> !o_tearing_sync_out_left;
    endproperty
    a_tear_off: assert property (p_tear_off) else $error("tearing out high while off"); // R8

    property p_tear_same;
        @(posedge i_mclk) disable iff (!i_reset_n)
        o_tearing_sync_out_right == o_tearing_sync_out_left;
    endproperty
    a_tear_same: assert property (p_tear_same) else $error("tearing outputs differ"); // R9

    property p_mddi_noswap;
        @(posedge i_mclk) disable iff (!i_reset_n)
        (cap_q && link_q == HISC_LINK_MDDI) |-> map_q == 2'h0;
    endproperty
    a_mddi_noswap: assert property (p_mddi_noswap) else $error("order swap in mddi"); // R4

    property p_addr;
        @(posedge i_mclk) disable iff (!i_reset_n)
        cap_q |-> (addr_q == 7'h4C || addr_q == 7'h4D);
    endproperty
    a_addr: assert property (p_addr) else $error("bad i2c address"); // R11

    property p_dio;
        @(posedge i_mclk) disable iff (!i_reset_n)
        !dio_q |-> !v18_q;
    endproperty
    a_dio: assert property (p_dio) else $error("1v8 without dual io"); // R12

    property p_cap_stable;
        @(posedge i_mclk) disable iff (!i_reset_n)
        cap_q |=> (cap_q && $stable(link_q) && $stable(addr_q));
    endproperty
    a_cap_stable: assert property (p_cap_stable) else $error("config changed"); // R16

    // Capture comes exactly on the edge after the settle count ends
    sequence s_settling;
        !cap_q && settle_q != 2'(STRAP_SETTLE_CYC);
    endsequence

    sequence s_settle_done;
        !cap_q && settle_q == 2'(STRAP_SETTLE_CYC);
    endsequence

    property p_cap_early;
        @(posedge i_mclk) disable iff (!i_reset_n)
        s_settling |=> !cap_q;
    endproperty
    a_cap_early: assert property (p_cap_early) else $error("straps captured early"); // R16

    property p_cap_time;
        @(posedge i_mclk) disable iff (!i_reset_n)
        s_settle_done |=> cap_q;
    endproperty
    a_cap_time: assert property (p_cap_time) else $error("straps not captured"); // R16

    property p_bl;
        @(posedge i_mclk) disable iff (!i_reset_n)
        i_backlight_on |=> o_backlight_on_out;
    endproperty
    a_bl: assert property (p_bl) else $error("backlight not on"); // R13

endmodule
`default_nettype wire

// file: bench/hisc_host_model.sv
// Purpose: Glass-side partner that closes the attach probe loop
// Assumes: Loop trace adds no delay
// Notes:   A broken trace returns the inverse of the driven level
`timescale 1ns/1ps
`default_nettype none
module hisc_host_model #(
    parameter int unsigned PROBE_N = 4
) (
    // Probe loop
    input  wire logic [PROBE_N-1:0] i_probe_out,
    input  wire logic               i_break,
    output logic      [PROBE_N-1:0] o_probe_in
);
    // Each probe output returns on its matching input
    assign o_probe_in = i_break ? ~i_probe_out : i_probe_out;
endmodule
`default_nettype wire

// file: bench/hisc_top_test.sv
// Purpose: Self-checking bench for strap decode and runtime pins
// Assumes: Straps are applied while reset is low
// Notes:   Each strap code needs its own reset since straps are captured once
`timescale 1ns/1ps
`default_nettype none
module hisc_top_test import hisc_pkg::*; ;
    // Stimulus
    logic       i_mclk, i_reset_n, lane_cnt, ord_swap, pol_swap, bypass, addr_lsb, volt_sel, dio_en;
    logic [3:0] strap_sel;
    logic       err_en, crc_err, tear_en, frame_sync, bl_on, full, probe_break;
    logic [7:0] duty;
    wire logic [3:0] probe_in;
    // Observed outputs
    logic       cfg_valid, two_lanes, lane_pol, line_buf, dio_reg, lvl18;
    logic       link_err, tear_l, tear_r, bl_out, pwm_out, attach_ok;
    hisc_link_e link_kind;
    hisc_cmd_e  cmd_kind;
    hisc_bus_e  bus_width;
    logic [1:0] lane_map;
    logic [6:0] i2c_addr;
    logic [3:0] probe_out, p;
    int         num_errors, samples_checked, cnt;

    hisc_top hisc_top_inst (
        .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_interface_select_strap(strap_sel),
        .i_lane_count_strap(lane_cnt), .i_lane_order_swap(ord_swap), .i_pair_polarity_swap(pol_swap),
        .i_rgb_bypass_strap(bypass), .i_slave_addr_lsb_strap(addr_lsb), .i_io_voltage_select(volt_sel),
        .i_dual_io_enable_strap(dio_en), .i_err_enable(err_en), .i_crc_ecc_error(crc_err),
        .i_tear_enable(tear_en), .i_frame_sync(frame_sync), .i_backlight_on(bl_on),
        .i_pwm_duty(duty), .i_pwm_full(full), .i_attach_probe_in(probe_in),
        .o_cfg_valid(cfg_valid), .o_link_kind(link_kind), .o_cmd_kind(cmd_kind),
        .o_bus_width(bus_width), .o_two_lanes(two_lanes), .o_lane_map(lane_map),
        .o_lane_pol(lane_pol), .o_rgb_to_line_buffer(line_buf), .o_i2c_slave_addr(i2c_addr),
        .o_dual_io_regulator(dio_reg), .o_io_level_1v8(lvl18), .o_link_error(link_err),
        .o_tearing_sync_out_left(tear_l), .o_tearing_sync_out_right(tear_r),
        .o_backlight_on_out(bl_out), .o_backlight_pwm_out(pwm_out),
        .o_attach_probe_out(probe_out), .o_attach_ok(attach_ok)
    );

    hisc_host_model hisc_host_model_inst (
        .i_probe_out(probe_out), .i_break(probe_break), .o_probe_in(probe_in)
    );

    // Clock at 200 MHz
    initial begin
        i_mclk = 1'b0;
        forever #2.5 i_mclk = ~i_mclk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask

    task automatic chk(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Reset with straps held, then check the captured configuration
    task automatic boot(input logic [3:0] c, input logic sw);
        hisc_link_e lk;
        hisc_cmd_e  ck;
        hisc_bus_e  bw;
        strap_sel = c;
        ord_swap  = sw;
        lane_cnt  = c[0];
        pol_swap  = c[1];
        bypass    = c[2];
        addr_lsb  = c[0];
        volt_sel  = c[1];
        dio_en    = c[3] ^ c[2];
        i_reset_n = 1'b0;
        tick(16);
        i_reset_n = 1'b1;
        tick(STRAP_SETTLE_CYC);
        chk(cfg_valid === 1'b0, "valid too early");
        tick(1);
        chk(cfg_valid === 1'b1, "config not captured");
        bw = HISC_BUS_NONE;
        case (c)
            4'h0: begin lk = HISC_LINK_PARALLEL; ck = HISC_CMD_PARALLEL; bw = HISC_BUS_8; end
            4'h1: begin lk = HISC_LINK_PARALLEL; ck = HISC_CMD_PARALLEL; bw = HISC_BUS_16; end
            4'h2: begin lk = HISC_LINK_PARALLEL; ck = HISC_CMD_PARALLEL; bw = HISC_BUS_24; end
            4'h3: begin lk = HISC_LINK_RGB; ck = HISC_CMD_SPI_RISE; end
            4'hB: begin lk = HISC_LINK_RGB; ck = HISC_CMD_SPI_FALL; end
            4'h4: begin lk = HISC_LINK_RGB; ck = HISC_CMD_I2C; end
            4'h5: begin lk = HISC_LINK_DSI; ck = HISC_CMD_DSI; end
            4'h6: begin lk = HISC_LINK_MDDI; ck = HISC_CMD_SPI_RISE; end
            4'hE: begin lk = HISC_LINK_MDDI; ck = HISC_CMD_SPI_FALL; end
            4'h7: begin lk = HISC_LINK_MDDI; ck = HISC_CMD_I2C; end
            default: begin lk = HISC_LINK_INVALID; ck = HISC_CMD_NONE; end
        endcase
        chk(link_kind === lk, "link kind");
        chk(cmd_kind === ck, "command kind");
        chk(bus_width === bw, "bus width");
        if (lk == HISC_LINK_DSI || lk == HISC_LINK_MDDI) chk(two_lanes === lane_cnt, "lanes");
        chk(lane_map === ((lk == HISC_LINK_DSI && sw) ? 2'h1 : 2'h0), "lane order");
        chk(lane_pol === pol_swap, "polarity");
        if (lk == HISC_LINK_RGB) chk(line_buf === bypass, "bypass");
        if (ck == HISC_CMD_I2C) chk(i2c_addr === (addr_lsb ? 7'h4D : 7'h4C), "slave address");
        chk(dio_reg === dio_en, "dual io regulator");
        chk(lvl18 === (dio_en & volt_sel), "io level");
        strap_sel = ~c;
        tick(3);
        chk(link_kind === lk, "late strap change");
    endtask

    // PWM high count over one full period once the duty has settled
    task automatic pwm_check(input logic [7:0] d, input logic f, input int exp);
        duty = d;
        full = f;
        tick(600);
        cnt = 0;
        repeat (PWM_STEPS) begin
            if (pwm_out === 1'b1) cnt++;
            tick(1);
        end
        chk(cnt == exp, "pwm duty");
    endtask

    // Watchdog
    initial begin
        #100000;
        num_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        report_and_stop();
    end

    // Main sequence
    initial begin
        {i_reset_n, strap_sel, lane_cnt, ord_swap, pol_swap, bypass, addr_lsb, volt_sel, dio_en} = '0;
        {err_en, crc_err, tear_en, frame_sync, bl_on, full, probe_break, duty} = '0;
        num_errors = 0;
        samples_checked = 0;
        for (int k = 0; k < 16; k++) boot(k[3:0], 1'b1);
        boot(4'h5, 1'b0);
        $display("test straps done");
        for (int k = 0; k < 8; k++) begin
            err_en = k[0];
            crc_err = k[1];
            tear_en = k[2];
            frame_sync = k[1];
            bl_on = k[0] ^ k[2];
            tick(1);
            chk(link_err === (k[0] & k[1]), "link error");
            chk(tear_l === (k[2] & k[1]), "tearing out");
            chk(tear_r === tear_l, "tearing right");
            chk(bl_out === (k[0] ^ k[2]), "backlight on");
        end
        $display("test runtime pins done");
        pwm_check(8'h00, 1'b0, 0);
        pwm_check(8'h01, 1'b0, 1);
        pwm_check(8'h80, 1'b0, 128);
        pwm_check(8'hFF, 1'b0, 255);
        pwm_check(8'h00, 1'b1, 256);
        $display("test pwm done");
        tick(2);
        chk(attach_ok === 1'b1, "loop closed");
        p = probe_out;
        tick(1);
        chk(probe_out === ~p, "probe pattern");
        probe_break = 1'b1;
        tick(2);
        chk(attach_ok === 1'b0, "loop broken");
        $display("test probes done");
        report_and_stop();
    end
endmodule
`default_nettype wire
